// ==== hw/dar_pkg.sv ====
// dar_pkg: constants and types for the dual channel converter readout
// assumes a single 250 MHz system clock drives every user of this package
package dar_pkg;
  localparam int RES_W = 12; // result word width
  localparam int CNT_W = 4; // serial clock counter width
  localparam int HOLD_W = 19; // hold timer width
  localparam logic [3:0] CNT_MODE = 4'h1; // clock of the input mode bit
  localparam logic [3:0] CNT_SIGN = 4'h2; // clock of channel/polarity bit
  localparam logic [3:0] CNT_REPEAT = 4'h3; // clock of repeat enable bit
  localparam logic [3:0] MSB_IDX = 4'hb; // index of the result msb
  localparam logic [3:0] LSB_IDX = 4'h0; // index of the result lsb
  localparam logic [3:0] REP_FIRST = 4'h1; // first bit of reversed repeat
  localparam logic [3:0] CNT_RST = 4'h0; // counter reset value
  localparam logic [11:0] RESULT_RST = 12'h000; // held result reset value
  localparam int CLK_PERIOD_PS = 4000; // mclk period
  localparam int HOLD_TIME_NS = 1200000; // sample charge retention time
  // longest time, so the division rounds down
  localparam int HOLD_CYCLES = (HOLD_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [18:0] HOLD_RST = 19'h00000; // hold timer reset value

  // serial engine states, one-hot
  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_WAIT_START = 6'h02,
    ST_COMMAND = 6'h04,
    ST_CONVERT = 6'h08,
    ST_REPEAT = 6'h10,
    ST_ZEROS = 6'h20
  } dar_state_t;
endpackage

// ==== hw/dar_sample_if.sv ====
// dar_sample_if: track/hold control and held result between serial engine
// and sample-and-hold; assumes both ends share the same mclk
`timescale 1ns/100ps
`default_nettype none
interface dar_sample_if;
  logic track; // follow the inputs while high, hold when low
  logic single_ended; // 1 single-ended, 0 pseudo-differential
  logic sel_odd; // channel select or polarity
  logic [11:0] result; // held conversion code
  modport engine (output track, output single_ended, output sel_odd,
                  input result);
  modport holder (input track, input single_ended, input sel_odd,
                  output result);
endinterface
`default_nettype wire

// ==== hw/dar_sample_hold.sv ====
// dar_sample_hold: tracks the selected input code and holds it
// assumes the analog inputs arrive as digitised codes synchronous to mclk
`timescale 1ns/100ps
`default_nettype none
module dar_sample_hold (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [11:0] analog_input_a, // first input code
  input wire logic [11:0] analog_input_b, // second input code
  dar_sample_if.holder sif // control in, held code out
);
  logic [11:0] hold_q;
  logic [11:0] hold_d;
  logic [11:0] code;

  // positive difference clamped at zero
  function automatic logic [11:0] sat_diff(input logic [11:0] p,
                                           input logic [11:0] n);
    sat_diff = (p > n) ? 12'(p - n) : 12'h000;
  endfunction

  // code selected by the configuration bits
  always_comb begin
    if (sif.single_ended) begin
      code = sif.sel_odd ? analog_input_b : analog_input_a;
    end else if (sif.sel_odd) begin
      code = sat_diff(analog_input_b, analog_input_a);
    end else begin
      code = sat_diff(analog_input_a, analog_input_b);
    end
    hold_d = sif.track ? code : hold_q;
  end

  // hold register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_q <= dar_pkg::RESULT_RST;
    end else begin
      hold_q <= hold_d;
    end
  end

  assign sif.result = hold_q;
endmodule
`default_nettype wire

// ==== hw/dar_readout.sv ====
// dar_readout: serial command decode and result shift-out of the converter
// assumes sclk, select_and_standby_n and din are synchronous to mclk
// Function
// R1 - The host changes its outgoing bit on falling clock and samples ours on rising clock.
// R2 - Zero bits on the command input before the first one bit are ignored.
// R3 - A byte-only host pads with leading zeros so the clock count is a multiple of eight.
// R4 - The link works with the serial clock idling low and with it idling high.
// R5 - With seven leading zeros the result msb leaves on the falling edge of clock 12.
// R6 - The result output stays undriven during the command and drives from the null bit on.
// R7 - In byte framing the second byte holds three unknown bits, null and four msbs, the third eight lsbs.
// R8 - After sampling, one result bit is resolved per serial clock.
// R9 - The host shifts all 12 result bits out within 1.2 ms of the end of sampling.
// R10 - Clock period and duty may vary across a conversion.
// R11 - The first clock edge with select low and data high is the start bit.
// R12 - After the start come the input mode bit, the channel/polarity bit and the repeat enable bit.
// R13 - A low null bit leaves on the repeat bit's falling edge, then 12 bits msb first, lsb first if enabled, then zeros.
// R14 - Select high ends any conversion and enters standby; the host raises it between conversions.
// R15 - The input is sampled from the second rising edge after the start to the third falling edge.
`timescale 1ns/100ps
`default_nettype none
module dar_readout #(
  parameter int HOLD_CYCLES = dar_pkg::HOLD_CYCLES // charge retention
) (
  input wire logic mclk, // system clock, 250 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic sclk, // serial clock from the host
  input wire logic select_and_standby_n, // chip select, active low
  input wire logic din, // serial command input
  input wire logic [11:0] analog_input_a, // first input code
  input wire logic [11:0] analog_input_b, // second input code
  output logic dout, // serial result output
  output logic dout_oe_n, // result output enable, low drives
  output logic standby, // engine in standby
  output logic [11:0] result_word, // held conversion code
  output logic hold_late // result not shifted out in time
);
  dar_sample_if sif ();
  dar_pkg::dar_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic mode_q, mode_d, odd_q, odd_d, rep_q, rep_d;
  logic dout_q, dout_d, oe_n_q, oe_n_d;
  logic armed_q, armed_d, sclk_q, standby_q, standby_d;
  logic [18:0] hold_cnt_q, hold_cnt_d;
  logic late_q, late_d;
  logic sel, rise, fall, cur_bit;

  // edges taken from the sampled clock, so either idle level works
  assign sel = ~select_and_standby_n;
  assign rise = sclk & ~sclk_q; // R4 R10
  assign fall = ~sclk & sclk_q; // R4 R10
  assign cur_bit = sif.result[cnt_q];

  dar_sample_hold u_hold (
    .mclk(mclk),
    .rst_n(rst_n),
    .analog_input_a(analog_input_a),
    .analog_input_b(analog_input_b),
    .sif(sif)
  );

  // track from the sign clock rise until the repeat clock fall
  assign sif.track = (state_q == dar_pkg::ST_COMMAND) &&
                     (cnt_q >= dar_pkg::CNT_SIGN); // R15
  assign sif.single_ended = mode_q;
  assign sif.sel_odd = odd_q;

  // serial engine next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    odd_d = odd_q;
    rep_d = rep_q;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    armed_d = armed_q | ~sel;
    standby_d = 1'b0;
    if (!sel) begin
      // select high aborts everything
      state_d = dar_pkg::ST_STANDBY; // R14
      oe_n_d = 1'b1; // R14
      dout_d = 1'b0;
      cnt_d = dar_pkg::CNT_RST;
      standby_d = 1'b1; // R14
    end else begin
      case (state_q)
        dar_pkg::ST_STANDBY: begin
          standby_d = ~armed_q;
          if (armed_q) begin
            state_d = dar_pkg::ST_WAIT_START;
          end
        end
        dar_pkg::ST_WAIT_START: begin
          // leading zeros pass without effect
          if (rise && din) begin // R2 R11
            state_d = dar_pkg::ST_COMMAND;
            cnt_d = dar_pkg::CNT_RST;
          end
        end
        dar_pkg::ST_COMMAND: begin
          if (rise) begin
            cnt_d = 4'(cnt_q + 4'h1);
            if (cnt_q == dar_pkg::CNT_RST) mode_d = din; // R12
            if (cnt_q == dar_pkg::CNT_MODE) odd_d = din; // R12
            if (cnt_q == dar_pkg::CNT_SIGN) rep_d = din; // R12
          end else if (fall && cnt_q == dar_pkg::CNT_REPEAT) begin
            // null bit starts driving the output
            dout_d = 1'b0; // R13
            oe_n_d = 1'b0; // R6
            cnt_d = dar_pkg::MSB_IDX; // R5
            state_d = dar_pkg::ST_CONVERT;
          end
        end
        dar_pkg::ST_CONVERT: begin
          if (fall) begin
            dout_d = cur_bit; // R8 R7 R5
            if (cnt_q == dar_pkg::LSB_IDX) begin
              cnt_d = dar_pkg::REP_FIRST;
              state_d = rep_q ? dar_pkg::ST_REPEAT : dar_pkg::ST_ZEROS;
            end else begin
              cnt_d = 4'(cnt_q - 4'h1);
            end
          end
        end
        dar_pkg::ST_REPEAT: begin
          // lsb is shared, so the reversed word continues at bit 1
          if (fall) begin
            dout_d = cur_bit; // R13
            if (cnt_q == dar_pkg::MSB_IDX) begin
              state_d = dar_pkg::ST_ZEROS;
            end else begin
              cnt_d = 4'(cnt_q + 4'h1);
            end
          end
        end
        dar_pkg::ST_ZEROS: begin
          if (fall) dout_d = 1'b0; // R13
        end
        default: begin
          state_d = dar_pkg::ST_STANDBY;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  // serial engine registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= dar_pkg::ST_STANDBY;
      cnt_q <= dar_pkg::CNT_RST;
      mode_q <= 1'b0;
      odd_q <= 1'b0;
      rep_q <= 1'b0;
      dout_q <= 1'b0;
      oe_n_q <= 1'b1;
      armed_q <= 1'b0;
      sclk_q <= 1'b0;
      standby_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      odd_q <= odd_d;
      rep_q <= rep_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
      armed_q <= armed_d;
      sclk_q <= sclk;
      standby_q <= standby_d;
    end
  end

  // charge retention timer from end of sampling to last msb-first bit
  always_comb begin
    hold_cnt_d = hold_cnt_q;
    late_d = late_q;
    if (state_q == dar_pkg::ST_WAIT_START &&
        state_d == dar_pkg::ST_COMMAND) begin
      hold_cnt_d = dar_pkg::HOLD_RST;
      late_d = 1'b0;
    end else if (state_q == dar_pkg::ST_CONVERT && !late_q) begin
      hold_cnt_d = 19'(hold_cnt_q + 19'h00001);
      if (hold_cnt_q >= 19'(HOLD_CYCLES - 1)) late_d = 1'b1; // R9
    end
  end

  // timer registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_cnt_q <= dar_pkg::HOLD_RST;
      late_q <= 1'b0;
    end else begin
      hold_cnt_q <= hold_cnt_d;
      late_q <= late_d;
    end
  end

  assign dout = dout_q;
  assign dout_oe_n = oe_n_q;
  assign standby = standby_q;
  assign result_word = sif.result;
  assign hold_late = late_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // checks on the serial engine
  a_select_high_standby: assert property ( // R14
    !sel |=> oe_n_q && state_q == dar_pkg::ST_STANDBY && standby_q)
    else $error("select high did not enter standby");
  a_command_undriven: assert property ( // R6
    (state_q == dar_pkg::ST_WAIT_START || state_q == dar_pkg::ST_COMMAND)
      |-> oe_n_q)
    else $error("output driven during command");
  a_zero_ignored: assert property ( // R2
    sel && state_q == dar_pkg::ST_WAIT_START && rise && !din
      |=> state_q == dar_pkg::ST_WAIT_START)
    else $error("leading zero taken as start");
  a_start_taken: assert property ( // R11
    sel && state_q == dar_pkg::ST_WAIT_START && rise && din
      |=> state_q == dar_pkg::ST_COMMAND && cnt_q == dar_pkg::CNT_RST)
    else $error("start bit missed");
  a_null_bit_low: assert property ( // R13
    sel && state_q == dar_pkg::ST_COMMAND && fall &&
      cnt_q == dar_pkg::CNT_REPEAT
      |=> !dout_q && !oe_n_q && cnt_q == dar_pkg::MSB_IDX)
    else $error("null bit wrong");
  a_result_bit_out: assert property ( // R8
    sel && state_q == dar_pkg::ST_CONVERT && fall
      |=> dout_q == $past(cur_bit))
    else $error("result bit wrong");
  a_bit_per_clock: assert property ( // R10
    sel && state_q == dar_pkg::ST_CONVERT && !fall ##1 sel
      |-> $stable(dout_q) && $stable(cnt_q))
    else $error("output moved without a falling edge");
  a_track_window: assert property ( // R15
    sel && state_q == dar_pkg::ST_COMMAND && rise &&
      cnt_q == dar_pkg::CNT_MODE ##1 sel |-> sif.track)
    else $error("sampling did not begin");
  a_tail_zeros: assert property ( // R13
    sel && state_q == dar_pkg::ST_ZEROS && fall |=> !dout_q && !oe_n_q)
    else $error("tail not zero");
  c_msb_only: cover property (
    state_q == dar_pkg::ST_CONVERT ##1 state_q == dar_pkg::ST_ZEROS);
  c_repeat_done: cover property (
    state_q == dar_pkg::ST_REPEAT ##1 state_q == dar_pkg::ST_ZEROS);
  c_abort_convert: cover property (
    state_q == dar_pkg::ST_CONVERT && !sel);
  c_hold_late: cover property ($rose(late_q));
endmodule
`default_nettype wire

// ==== verification/dar_host_model.sv ====
// dar_host_model: serial master facing the readout block, up to 40 clocks per frame
// assumes mclk is the bench clock; every pin changes at its falling edge
`timescale 1ns/100ps
`default_nettype none
module dar_host_model (
  input wire logic mclk, // bench clock
  output logic sclk, // serial clock
  output logic select_and_standby_n, // chip select, active low
  output logic din, // command bits
  input wire logic dout, // result bit
  input wire logic dout_oe_n // low while the result is driven
);
  logic cap_d [1:40];
  logic cap_z [1:40];
  logic last;

  // idle with select high so a power-up low is never seen
  initial begin
    sclk = 1'b0;
    select_and_standby_n = 1'b1;
    din = 1'b0;
    last = 1'b0;
  end

  // one frame: lead zeros, start, three config bits, then zeros
  task automatic frame(input int lead, input logic [2:0] cfg,
                       input logic cpol, input int nclk, input int slow);
    int k;
    @(negedge mclk);
    sclk <= cpol;
    repeat (4) @(negedge mclk);
    select_and_standby_n <= 1'b0;
    repeat (2) @(negedge mclk);
    for (k = 1; k <= nclk; k++) begin
      sclk <= 1'b0;
      din <= (k == lead + 1) ? 1'b1 : (k > lead + 1 && k <= lead + 4) ?
             cfg[lead + 4 - k] : 1'b0;
      // undriven pin reads as the inverse of the last bit
      repeat (slow + 3 + $urandom_range(3)) @(negedge mclk);
      sclk <= 1'b1;
      cap_d[k] = dout_oe_n ? ~last : dout;
      cap_z[k] = dout_oe_n;
      last = cap_d[k];
      repeat (2 + $urandom_range(3)) @(negedge mclk);
    end
    sclk <= cpol;
    din <= 1'b0;
    repeat (2) @(negedge mclk);
    select_and_standby_n <= 1'b1;
    repeat (3) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_dual_channel_adc_serial_readout.sv ====
// tb_dual_channel_adc_serial_readout: random and corner frames on readout
// assumes the host model paces the link; bench sets the input codes
`timescale 1ns/100ps
`default_nettype none
module tb_dual_channel_adc_serial_readout;
  logic mclk, rst_n, sclk, select_and_standby_n, din, dout, dout_oe_n;
  logic standby, hold_late;
  logic [11:0] analog_input_a, analog_input_b, result_word;
  int err_total, n_compared, i;

  dar_readout #(.HOLD_CYCLES(200)) dar_readout_i (.mclk(mclk),
    .rst_n(rst_n), .sclk(sclk), .din(din),
    .select_and_standby_n(select_and_standby_n),
    .analog_input_a(analog_input_a), .analog_input_b(analog_input_b),
    .dout(dout), .dout_oe_n(dout_oe_n), .standby(standby),
    .result_word(result_word), .hold_late(hold_late));
  dar_host_model dar_host_model_i (.mclk(mclk), .sclk(sclk),
    .select_and_standby_n(select_and_standby_n), .din(din), .dout(dout),
    .dout_oe_n(dout_oe_n));

  // 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task summarize;
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected code from mode, channel/polarity and both inputs
  function automatic logic [11:0] code_of(logic [2:0] c, logic [11:0] a,
                                          logic [11:0] b);
    if (c[2]) return c[1] ? b : a;
    if (c[1]) return (b > a) ? b - a : 12'h000;
    return (a > b) ? a - b : 12'h000;
  endfunction

  // bit j after the null bit: msb first, optional repeat, then zeros
  function automatic logic exp_bit(int j, logic rep, logic [11:0] c);
    if (j >= 1 && j <= 12) return c[12 - j];
    if (rep && j >= 13 && j <= 23) return c[j - 12];
    return 1'b0;
  endfunction

  // run one frame and compare every captured bit
  task automatic run(int lead, logic [2:0] cfg, logic cpol, int nclk,
                     int slow);
    int k;
    logic [11:0] c;
    c = code_of(cfg, analog_input_a, analog_input_b);
    dar_host_model_i.frame(lead, cfg, cpol, nclk, slow);
    for (k = 1; k <= nclk; k++) begin
      if (k < lead + 5) begin
        check(12'(dar_host_model_i.cap_z[k]), 12'h001);
      end else begin
        check(12'(dar_host_model_i.cap_z[k]), 12'h000);
        check(12'(dar_host_model_i.cap_d[k]),
              12'(exp_bit(k - lead - 5, cfg[0], c)));
      end
    end
    if (nclk >= lead + 17) begin
      check(result_word, c);
      check(12'(hold_late), 12'(slow > 0));
      // inputs move in standby: the held code must not follow them
      analog_input_a <= ~analog_input_a;
      analog_input_b <= ~analog_input_b;
      @(negedge mclk);
      check(result_word, c);
    end
    check(12'(standby), 12'h001);
    check(12'(dout_oe_n), 12'h001);
  endtask

  // watchdog well beyond the longest run
  initial begin
    repeat (40000) @(posedge mclk);
    err_total++;
    summarize;
  end

  // main sequence
  initial begin
    err_total = 0;
    n_compared = 0;
    rst_n = 1'b0;
    analog_input_a = 12'h000;
    analog_input_b = 12'h000;
    void'($urandom(75));
    repeat (20) @(negedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    check(12'(dout_oe_n), 12'h001);
    check(12'(standby), 12'h001);
    check(result_word, 12'h000);
    for (i = 0; i < 16; i++) begin
      analog_input_a <= (i == 0) ? 12'hfff : (i == 1) ? 12'h000 :
                        12'($urandom);
      analog_input_b <= (i == 0) ? 12'h000 : (i == 1) ? 12'hfff :
                        12'($urandom);
      @(negedge mclk);
      run(7, i[2:0], i[3], i[0] ? 40 : 24, 0);
    end
    run(int'($urandom_range(6)), 3'b101, 1'b0, 34, 0);
    run(7, 3'b010, 1'b1, 14, 0);
    run(7, 3'b100, 1'b0, 24, 20);
    run(7, 3'b110, 1'b1, 24, 0);
    summarize;
  end
endmodule
`default_nettype wire
